// [design/smi_status_params.svh]
`ifndef SMI_STATUS_PARAMS_SVH
`define SMI_STATUS_PARAMS_SVH
// Memory window offsets (byte addresses)
`define OFF_TOP_MIRROR 8'h00
`define OFF_TOP_CLEAR 8'h02
`define OFF_TT_MIRROR 8'h04
`define OFF_TT_CLEAR 8'h06
// Configuration indices
`define IDX_PM1_MIRROR 8'h84
`define IDX_PM1_CLEAR 8'hF4
`define IDX_PM4_MIRROR 8'h87
`define IDX_PM4_CLEAR 8'hF7
`define IDX_CFG_53 8'h53
`define IDX_CFG_83 8'h83
`define IDX_CFG_82 8'h82
`define IDX_CFG_97 8'h97
`define IDX_CFG_92 8'h92
`define IDX_CFG_90 8'h90
// Top-level bit positions
`define TOP_PM 0
`define TOP_AUDIO 1
`define TOP_VGA 6
`define TOP_A20 7
`define TOP_SW 8
`define TOP_TT 9
`define TOP_NMI 12
`define TOP_WARM 13
`define TOP_USB 14
// Enable bit positions
`define CFG53_A20 0
`define CFG53_GAME_WR 3
`define CFG83_TMR1 0
`define CFG83_TMR2 1
`define CFG83_VGA 3
`define CFG83_GAME_RD 4
`define CFG82_USER_TRAP 4
// Trap/timer and power-management status 1 bit positions
`define TT_TMR1 0
`define TT_USER_TRAP 2
`define TT_PCI 5
`define PM1_GAME 4
// Reset values
`define RST_TOP 16'h0000
`define RST_TT 16'h0000
`define RST_PM 8'h00
`define RST_CFG 8'h00
`endif

// [design/smi_status_pkg.sv]
package smi_status_pkg;
   typedef logic [15:0] word_t;
   typedef logic [7:0] byte_t;
endpackage : smi_status_pkg

// [design/smi_status_hierarchy.sv]
`timescale 1ns/1ps
`default_nettype none
`include "smi_status_params.svh"
module smi_status_hierarchy #(
   parameter int NUM_PINS = 4
) (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   // Memory window access
   input wire logic mem_rd_in,
   input wire logic [7:0] mem_addr_in,
   output logic [15:0] mem_rdata_out,
   // Configuration index access
   input wire logic cfg_rd_in,
   input wire logic cfg_wr_in,
   input wire logic [7:0] cfg_idx_in,
   input wire logic [7:0] cfg_wdata_in,
   output logic [7:0] cfg_rdata_out,
   // Event inputs, one-cycle pulses from same-clock logic except gen_pin_low_evt_in, which passes a two-stage synchroniser
   input wire logic usb_evt_in,
   input wire logic warm_reset_evt_in,
   input wire logic nmi_evt_in,
   input wire logic sw_evt_in,
   input wire logic a20_toggle_evt_in,
   input wire logic vga_timer_evt_in,
   input wire logic audio_evt_in,
   input wire logic [4:0] pci_func_trap_evt_in,
   input wire logic [4:0] pci_func_trap_en_in,
   input wire logic [2:0] user_trap_evt_in,
   input wire logic [1:0] gp_timer_evt_in,
   input wire logic game_rd_evt_in,
   input wire logic game_wr_evt_in,
   input wire logic [2:0] gen_pin_low_evt_in,
   // Asynchronous pins 7,5,4,3 in bit order 3..0
   input wire logic [NUM_PINS-1:0] gen_pin_in,
   input wire logic [NUM_PINS-1:0] gen_pin_sel_in,
   output logic mgmt_irq_n_out
);
   smi_status_pkg::word_t top_status;
   smi_status_pkg::word_t tt_status;
   smi_status_pkg::byte_t pm1_status;
   smi_status_pkg::byte_t pm4_status;
   smi_status_pkg::byte_t cfg53, cfg82, cfg83, cfg90, cfg92, cfg97;
   logic [NUM_PINS-1:0] pin_meta, pin_sync, pin_prev;
   logic [2:0] low_sync_meta, low_sync;
   smi_status_pkg::word_t next_top, next_tt, top_set, tt_set;
   smi_status_pkg::byte_t next_pm1, next_pm4, pm1_set, pm4_set;
   logic [NUM_PINS-1:0] pin_edge;

   // Register decodes; only the clearing offsets have a side effect
   wire rd_top_clr = mem_rd_in && mem_addr_in == `OFF_TOP_CLEAR;
   wire rd_tt_clr = mem_rd_in && mem_addr_in == `OFF_TT_CLEAR;
   wire rd_pm1_clr = cfg_rd_in && cfg_idx_in == `IDX_PM1_CLEAR;
   wire rd_pm4_clr = cfg_rd_in && cfg_idx_in == `IDX_PM4_CLEAR;
   wire wr_53 = cfg_wr_in && cfg_idx_in == `IDX_CFG_53;
   wire wr_82 = cfg_wr_in && cfg_idx_in == `IDX_CFG_82;
   wire wr_83 = cfg_wr_in && cfg_idx_in == `IDX_CFG_83;
   wire wr_90 = cfg_wr_in && cfg_idx_in == `IDX_CFG_90;
   wire wr_92 = cfg_wr_in && cfg_idx_in == `IDX_CFG_92;
   wire wr_97 = cfg_wr_in && cfg_idx_in == `IDX_CFG_97;

   // Pin edge detection after a two-stage synchroniser
   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : g_pin
         // Pin must be selected, an input and enabled
         assign pin_edge[g] = (pin_sync[g] ^ pin_prev[g]) && gen_pin_sel_in[g]
            && !cfg90[g] && cfg97[g];
      end
   endgenerate

   // Trap/timer group set terms
   wire pci_trap = |(pci_func_trap_evt_in & pci_func_trap_en_in);
   always_comb begin
      tt_set = 16'h0000;
      tt_set[`TT_PCI] = pci_trap;
      tt_set[`TT_USER_TRAP +: 3] = user_trap_evt_in
         & cfg82[`CFG82_USER_TRAP +: 3];
      tt_set[`TT_TMR1 +: 2] = gp_timer_evt_in
         & cfg83[`CFG83_TMR1 +: 2];
   end

   // Power-management group set terms
   wire game_hit = (game_rd_evt_in && cfg83[`CFG83_GAME_RD])
      || (game_wr_evt_in && cfg53[`CFG53_GAME_WR]);
   always_comb begin
      pm1_set = 8'h00;
      pm1_set[`PM1_GAME] = game_hit;
      pm1_set[NUM_PINS-1:0] = pin_edge;
      pm4_set = 8'h00;
      pm4_set[7:5] = low_sync & cfg92[2:0];
   end

   // Top-level set terms
   always_comb begin
      top_set = 16'h0000;
      top_set[`TOP_USB] = usb_evt_in;
      top_set[`TOP_WARM] = warm_reset_evt_in;
      top_set[`TOP_NMI] = nmi_evt_in;
      top_set[`TOP_SW] = sw_evt_in;
      top_set[`TOP_A20] = a20_toggle_evt_in && cfg53[`CFG53_A20];
      top_set[`TOP_VGA] = vga_timer_evt_in && cfg83[`CFG83_VGA];
      top_set[`TOP_AUDIO] = audio_evt_in;
      top_set[`TOP_TT] = |tt_set;
      top_set[`TOP_PM] = |pm1_set || |pm4_set;
   end

   // Set wins over a coincident clearing read
   assign next_top = (rd_top_clr ? 16'h0000 : top_status) | top_set;
   assign next_tt = (rd_tt_clr ? 16'h0000 : tt_status) | tt_set;
   assign next_pm1 = (rd_pm1_clr ? 8'h00 : pm1_status) | pm1_set;
   assign next_pm4 = (rd_pm4_clr ? 8'h00 : pm4_status) | pm4_set;

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         top_status <= `RST_TOP;
         tt_status <= `RST_TT;
         pm1_status <= `RST_PM;
         pm4_status <= `RST_PM;
      end else begin
         top_status <= next_top;
         tt_status <= next_tt;
         pm1_status <= next_pm1;
         pm4_status <= next_pm4;
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cfg53 <= `RST_CFG;
         cfg82 <= `RST_CFG;
         cfg83 <= `RST_CFG;
         cfg90 <= `RST_CFG;
         cfg92 <= `RST_CFG;
         cfg97 <= `RST_CFG;
      end else begin
         if (wr_53) cfg53 <= cfg_wdata_in;
         if (wr_82) cfg82 <= cfg_wdata_in;
         if (wr_83) cfg83 <= cfg_wdata_in;
         if (wr_90) cfg90 <= cfg_wdata_in;
         if (wr_92) cfg92 <= cfg_wdata_in;
         if (wr_97) cfg97 <= cfg_wdata_in;
      end
   end

   // Synchronisers; first stage feeds only the second
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pin_meta <= '0;
         pin_sync <= '0;
         pin_prev <= '0;
         low_sync_meta <= 3'h0;
         low_sync <= 3'h0;
      end else begin
         pin_meta <= gen_pin_in;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
         low_sync_meta <= gen_pin_low_evt_in;
         low_sync <= low_sync_meta;
      end
   end

   // Read data muxes; mirror and clearing copy return the same data
   smi_status_pkg::word_t next_mem_rdata;
   smi_status_pkg::byte_t next_cfg_rdata;
   wire sel_top = mem_addr_in == `OFF_TOP_MIRROR
      || mem_addr_in == `OFF_TOP_CLEAR;
   wire sel_tt = mem_addr_in == `OFF_TT_MIRROR
      || mem_addr_in == `OFF_TT_CLEAR;
   wire sel_pm1 = cfg_idx_in == `IDX_PM1_MIRROR
      || cfg_idx_in == `IDX_PM1_CLEAR;
   wire sel_pm4 = cfg_idx_in == `IDX_PM4_MIRROR
      || cfg_idx_in == `IDX_PM4_CLEAR;
   assign next_mem_rdata = sel_top ? top_status :
      sel_tt ? tt_status : 16'h0000;
   assign next_cfg_rdata = sel_pm1 ? pm1_status :
      sel_pm4 ? pm4_status :
      cfg_idx_in == `IDX_CFG_53 ? cfg53 :
      cfg_idx_in == `IDX_CFG_82 ? cfg82 :
      cfg_idx_in == `IDX_CFG_83 ? cfg83 :
      cfg_idx_in == `IDX_CFG_90 ? cfg90 :
      cfg_idx_in == `IDX_CFG_92 ? cfg92 :
      cfg_idx_in == `IDX_CFG_97 ? cfg97 : 8'h00;

   // Read data is sampled together with the clear, so the value read is
   // the one that was pending just before clearing.
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mem_rdata_out <= 16'h0000;
         cfg_rdata_out <= 8'h00;
         mgmt_irq_n_out <= 1'b1;
      end else begin
         if (mem_rd_in) mem_rdata_out <= next_mem_rdata;
         if (cfg_rd_in) cfg_rdata_out <= next_cfg_rdata;
         // Held low until every level is empty
         mgmt_irq_n_out <= !(|next_top || |next_tt || |next_pm1
            || |next_pm4);
      end
   end

   // Interrupt output is low while the top word is pending and high once every level is empty
   AST_IRQ_FOLLOWS: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (|top_status) |-> !mgmt_irq_n_out)
      else $error("irq high while status pending");
   AST_IRQ_RELEASE: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (top_status == 16'h0000 && tt_status == 16'h0000
      && pm1_status == 8'h00 && pm4_status == 8'h00) |-> mgmt_irq_n_out)
      else $error("irq low with nothing pending");
   AST_MIRROR_IRQ: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      mem_rd_in && mem_addr_in == `OFF_TOP_MIRROR && !mgmt_irq_n_out
      |=> !mgmt_irq_n_out)
      else $error("mirror read released irq");

   // Top-level word
   AST_TOP_CLEAR: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      rd_top_clr && top_set == 16'h0000 |=> top_status == 16'h0000)
      else $error("top read did not clear");
   AST_MIRROR_KEEP: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      mem_rd_in && mem_addr_in == `OFF_TOP_MIRROR
      |=> $past(top_status) == (top_status & $past(top_status)))
      else $error("mirror read cleared bits");
   AST_TOP_RDATA: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      mem_rd_in && sel_top |=> mem_rdata_out == $past(top_status))
      else $error("top read data differs from status");

   AST_USB_SET: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      usb_evt_in |=> top_status[`TOP_USB])
      else $error("usb bit not set");
   AST_WARM_SET: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      warm_reset_evt_in |=> top_status[`TOP_WARM])
      else $error("warm reset bit not set");
   AST_NMI_SET: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      nmi_evt_in |=> top_status[`TOP_NMI])
      else $error("nmi bit not set");
   AST_SW_SET: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      sw_evt_in |=> top_status[`TOP_SW])
      else $error("software bit not set");
   AST_A20_SET: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      a20_toggle_evt_in && cfg53[`CFG53_A20] |=> top_status[`TOP_A20])
      else $error("bit 7 not set");
   AST_VGA_SET: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      vga_timer_evt_in && cfg83[`CFG83_VGA] |=> top_status[`TOP_VGA])
      else $error("vga timer bit not set");
   AST_AUDIO_SET: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      audio_evt_in |=> top_status[`TOP_AUDIO])
      else $error("audio bit not set");
   AST_A20_GATE: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      a20_toggle_evt_in && !cfg53[`CFG53_A20]
      && !rd_top_clr && !top_status[`TOP_A20] |=> !top_status[`TOP_A20])
      else $error("disabled bit 7 source set");

   // Trap/timer group
   AST_TT_CLEAR: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      rd_tt_clr && tt_set == 16'h0000 |=> tt_status == 16'h0000)
      else $error("trap group read did not clear");
   AST_TT_MIRROR_KEEP: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      mem_rd_in && mem_addr_in == `OFF_TT_MIRROR
      |=> ($past(tt_status) & ~tt_status) == 16'h0000)
      else $error("trap mirror read cleared bits");
   AST_TT_SUMMARY: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      |tt_set |=> top_status[`TOP_TT])
      else $error("summary bit 9 missing");
   AST_PCI_SET: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      pci_trap |=> tt_status[`TT_PCI])
      else $error("function trap bit not set");

   // Power-management groups
   AST_PM_SUMMARY: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      |pm1_set |=> top_status[`TOP_PM] && |pm1_status)
      else $error("pm summary missing");
   AST_GAME_SET: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      game_hit |=> pm1_status[`PM1_GAME])
      else $error("game port bit not set");
   AST_PIN_SET: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      |pin_edge |=> |pm1_status[NUM_PINS-1:0])
      else $error("pin transition not recorded");
   AST_PM1_CLEAR: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      rd_pm1_clr && pm1_set == 8'h00 |=> pm1_status == 8'h00)
      else $error("pm status 1 read did not clear");
   AST_PM1_MIRROR_KEEP: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      cfg_rd_in && cfg_idx_in == `IDX_PM1_MIRROR
      |=> ($past(pm1_status) & ~pm1_status) == 8'h00)
      else $error("pm status 1 mirror cleared bits");
   AST_PM4_CLEAR: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      rd_pm4_clr && pm4_set == 8'h00 |=> pm4_status == 8'h00)
      else $error("low pin status read did not clear");
   AST_PM4_MIRROR_KEEP: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      cfg_rd_in && cfg_idx_in == `IDX_PM4_MIRROR
      |=> ($past(pm4_status) & ~pm4_status) == 8'h00)
      else $error("low pin mirror cleared bits");
   AST_SET_WINS: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      rd_pm1_clr && game_hit |=> pm1_status[`PM1_GAME])
      else $error("event lost at clear");
   AST_PM1_RSVD: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      pm1_status[7:5] == 3'h0 && tt_status[15:6] == 10'h000)
      else $error("reserved bit set");
endmodule : smi_status_hierarchy
`default_nettype wire

// [tb/host_irq_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_irq_model (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic mgmt_irq_n_in,
   output logic [7:0] entry_count_out
);
   logic irq_q;
   // One entry per falling edge; a request held low is one episode
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         irq_q <= 1'b1;
         entry_count_out <= 8'h00;
      end else begin
         irq_q <= mgmt_irq_n_in;
         if (irq_q && !mgmt_irq_n_in) begin
            entry_count_out <= entry_count_out + 8'h01;
         end
      end
   end
endmodule : host_irq_model
`default_nettype wire

// [tb/smi_status_hierarchy_test.sv]
`timescale 1ns/1ps
`default_nettype none
module smi_status_hierarchy_test;
   logic clk = 1'b0, rst = 1'b1, mrd = 1'b0, crd = 1'b0, cwr = 1'b0;
   logic grd = 1'b0, gwr = 1'b0, mpend = 1'b0, cpend = 1'b0;
   logic [7:0] maddr = 8'h00, cidx = 8'h00, cwd = 8'h00;
   logic [6:0] tev = 7'h00;
   logic [4:0] pev = 5'h00, pen = 5'h00;
   logic [2:0] uev = 3'h0, lev = 3'h0;
   logic [1:0] gev = 2'h0;
   logic [3:0] pin = 4'h0;
   logic [15:0] w;
   logic [31:0] seed = 32'h17F516D6;
   wire logic [15:0] mdata;
   wire logic [7:0] cdata, entries;
   wire logic irq_n;
   logic [15:0] exp_m[$];
   logic [7:0] exp_c[$];
   int bad_count = 0, compares = 0, episodes = 0;
   localparam logic [15:0] TOPB [7] = '{16'h4000, 16'h2000, 16'h1000,
      16'h0100, 16'h0080, 16'h0040, 16'h0002};
   localparam logic [15:0] TTB [6] = '{16'h0004, 16'h0008, 16'h0010,
      16'h0001, 16'h0002, 16'h0020};

   smi_status_hierarchy u_smi_status_hierarchy (
      .clk_sys_in(clk), .sys_rst_in(rst),
      .mem_rd_in(mrd), .mem_addr_in(maddr), .mem_rdata_out(mdata),
      .cfg_rd_in(crd), .cfg_wr_in(cwr), .cfg_idx_in(cidx),
      .cfg_wdata_in(cwd), .cfg_rdata_out(cdata),
      .usb_evt_in(tev[0]), .warm_reset_evt_in(tev[1]), .nmi_evt_in(tev[2]),
      .sw_evt_in(tev[3]), .a20_toggle_evt_in(tev[4]),
      .vga_timer_evt_in(tev[5]), .audio_evt_in(tev[6]),
      .pci_func_trap_evt_in(pev), .pci_func_trap_en_in(pen),
      .user_trap_evt_in(uev), .gp_timer_evt_in(gev),
      .game_rd_evt_in(grd), .game_wr_evt_in(gwr),
      .gen_pin_low_evt_in(lev), .gen_pin_in(pin),
      .gen_pin_sel_in(4'hF), .mgmt_irq_n_out(irq_n));

   host_irq_model u_host_irq_model (.clk_sys_in(clk), .sys_rst_in(rst),
      .mgmt_irq_n_in(irq_n), .entry_count_out(entries));

   initial begin
      forever #10 clk = ~clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      xs = v ^ (v << 5);
   endfunction : xs

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      compares++;
      if (seen !== want) begin
         bad_count++;
         $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
      end
   endtask : check

   task automatic irq(input logic v);
      check({15'h0000, irq_n}, {15'h0000, v});
   endtask : irq

   task automatic mread(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      #2 mrd = 1'b1;
      maddr = a;
      exp_m.push_back(e);
      @(posedge clk);
      #2 mrd = 1'b0;
   endtask : mread

   task automatic cacc(input logic wr, input logic [7:0] i,
                       input logic [7:0] d);
      @(posedge clk);
      #2 cwr = wr;
      crd = !wr;
      cidx = i;
      cwd = d;
      if (!wr) exp_c.push_back(d);
      @(posedge clk);
      #2 cwr = 1'b0;
      crd = 1'b0;
   endtask : cacc

   task automatic fire(input logic [6:0] t, input logic [2:0] u,
      input logic [1:0] g, input logic [4:0] p, input logic [1:0] gm);
      @(posedge clk);
      #2 {tev, uev, gev, pev, gwr, grd} = {t, u, g, p, gm};
      @(posedge clk);
      #2 {tev, uev, gev, pev, gwr, grd} = 19'h00000;
   endtask : fire

   task automatic print_verdict();
      if (bad_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict

   // Read data lands one edge after the strobe, so compare a cycle later
   always @(posedge clk) begin
      if (mpend) check(mdata, exp_m.pop_front());
      if (cpend) check({8'h00, cdata}, {8'h00, exp_c.pop_front()});
      mpend <= mrd;
      cpend <= crd;
   end

   initial begin
      #400000;
      bad_count++;
      print_verdict();
   end

   initial begin
      repeat (20) @(posedge clk);
      #2 rst = 1'b0;
      irq(1'b1);
      mread(8'h06, 16'h0000);
      mread(8'h08, 16'h0000);
      cacc(1'b0, 8'hF4, 8'h00);
      cacc(1'b1, 8'h53, 8'h09);
      cacc(1'b1, 8'h83, 8'h1B);
      cacc(1'b1, 8'h82, 8'h70);
      cacc(1'b1, 8'h97, 8'h01);
      cacc(1'b0, 8'h83, 8'h1B);
      for (int i = 0; i < 7; i++) begin
         fire(7'h01 << i, 3'h0, 2'h0, 5'h00, 2'h0);
         irq(1'b0);
         mread(8'h00, TOPB[i]);
         irq(1'b0);
         mread(8'h02, TOPB[i]);
         mread(8'h00, 16'h0000);
         irq(1'b1);
         episodes++;
      end
      for (int j = 0; j < 6; j++) begin
         seed = xs(seed);
         pen = seed[4:0];
         fire(7'h00, TTB[j][4:2], TTB[j][1:0],
              TTB[j][5] ? seed[9:5] : 5'h00, 2'h0);
         w = (j == 5 && (seed[9:5] & seed[4:0]) == 5'h00) ? 16'h0000 : TTB[j];
         irq(w == 16'h0000);
         mread(8'h04, w);
         mread(8'h00, (w != 16'h0000) ? 16'h0200 : 16'h0000);
         mread(8'h06, w);
         mread(8'h04, 16'h0000);
         mread(8'h02, (w != 16'h0000) ? 16'h0200 : 16'h0000);
         irq(1'b1);
         if (w != 16'h0000) episodes++;
      end
      for (int k = 0; k < 2; k++) begin
         fire(7'h00, 3'h0, 2'h0, 5'h00, (k == 0) ? 2'b01 : 2'b10);
         cacc(1'b0, 8'h84, 8'h10);
         mread(8'h00, 16'h0001);
         cacc(1'b0, 8'hF4, 8'h10);
         cacc(1'b0, 8'h84, 8'h00);
         mread(8'h02, 16'h0001);
         irq(1'b1);
         episodes++;
      end
      #2 pin = 4'h1;
      repeat (6) @(posedge clk);
      cacc(1'b0, 8'hF4, 8'h01);
      mread(8'h02, 16'h0001);
      irq(1'b1);
      fork
         fire(7'h01, 3'h0, 2'h0, 5'h00, 2'h0);
         mread(8'h02, 16'h0000);
      join
      irq(1'b0);
      mread(8'h02, 16'h4000);
      irq(1'b1);
      episodes += 2;
      cacc(1'b1, 8'h92, 8'h07);
      #2 lev = 3'h1;
      repeat (2) @(posedge clk);
      #2 lev = 3'h0;
      repeat (4) @(posedge clk);
      irq(1'b0);
      cacc(1'b0, 8'h87, 8'h20);
      cacc(1'b0, 8'hF7, 8'h20);
      cacc(1'b0, 8'h87, 8'h00);
      mread(8'h02, 16'h0001);
      irq(1'b1);
      episodes++;
      repeat (2) @(posedge clk);
      check({8'h00, entries}, 16'(episodes));
      print_verdict();
   end
endmodule : smi_status_hierarchy_test
`default_nettype wire
